//--- ltf_framer.sv
// Purpose: parses legacy 64/16-bit transmit requests, answers with status
// Assumes: rx, req, payload, completion and tx streams share core_clk
// Notes: one request in flight; the next frame waits for its completion
// Behaviour
// - Two length bytes after 0x7E count bytes between length and checksum.
// - Type byte 0x00 at offset 3 means request with 64-bit address.
// - Type byte 0x01 means request with 16-bit network address.
// - Identifier at offset 4; zero suppresses status, nonzero requests it.
// - Status frame echoes the request identifier unchanged.
// - Long request: eight address bytes from offset 5, 0xFFFF is broadcast.
// - Short request: two address bytes from offset 5, 0xFFFF broadcast.
// - Options at 13 or 7; bit 0 disables the MAC acknowledgement.
// - Option bit 2 sends with broadcast PAN identifier.
// - Options may be combined; each applies on its own.
// - Payload from offset 14 or 8 up to checksum, passed unchanged.
// - Checksum is 0xFF minus low byte of sum from offset 3.
// - Completion emits a type 0x89 frame carrying the status.
// - Broadcast requests always report status 0x00.
// - Status frame holds identifier at offset 4, status at offset 5.
`timescale 1ns/1ps
module ltf_framer
    import ltf_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [7:0] rx_data,
    output ltf_pkg::ltf_req_t req,
    output logic req_valid,
    input wire logic req_ready,
    output logic pay_valid,
    input wire logic pay_ready,
    output ltf_pkg::ltf_byte_t pay_data,
    input wire logic done_valid,
    input wire logic [7:0] done_status,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [7:0] tx_data,
    output logic frame_drop
);
    import ltf_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LEN_HI,
        ST_LEN_LO,
        ST_BODY,
        ST_CKSUM,
        ST_WAIT,
        ST_EMIT
    } ltf_state_t;

    ltf_state_t state_reg, state_next;
    logic [7:0] len_hi_reg;
    logic [15:0] rem_reg;
    logic [15:0] bidx_reg;
    logic [7:0] sum_reg;
    logic type_ok_reg;
    logic long_reg;
    logic [7:0] id_reg;
    logic [63:0] dest_reg;
    logic [7:0] opt_reg;
    logic ovf_reg;
    logic req_valid_reg;
    ltf_req_t req_reg;
    logic drop_reg;

    wire take = clk_en && rx_valid && rx_ready;
    wire in_body = state_reg == ST_BODY;
    wire [15:0] len_word = {len_hi_reg, rx_data};
    wire [15:0] pay_idx = long_reg ? BI_PAY64 : BI_PAY16;
    wire [15:0] opt_idx = long_reg ? BI_OPT64 : BI_OPT16;
    wire [15:0] dest_end = long_reg ? BI_OPT64 : BI_OPT16;
    wire is_type = in_body && bidx_reg == '0;
    wire is_id = in_body && bidx_reg == BI_ID;
    wire is_dest = in_body && type_ok_reg && bidx_reg >= BI_DEST
        && bidx_reg < dest_end;
    wire is_opt = in_body && type_ok_reg && bidx_reg == opt_idx;
    wire is_pay = in_body && type_ok_reg && bidx_reg >= pay_idx;
    wire pay_last = rem_reg == ONE16;
    wire fifo_in_ready;
    wire fifo_push = take && is_pay && !ovf_reg;
    wire [7:0] ck_want = CKSUM_BASE - sum_reg;
    wire ck_ok = rx_data == ck_want;
    wire hdr_ok = type_ok_reg && bidx_reg >= pay_idx && !ovf_reg;
    wire good = take && state_reg == ST_CKSUM && ck_ok && hdr_ok;
    wire bad = take && state_reg == ST_CKSUM && !(ck_ok && hdr_ok);
    wire bcast_hit = long_reg ? dest_reg == BCAST64
        : dest_reg[15:0] == BCAST16;
    wire done_take = clk_en && state_reg == ST_WAIT && done_valid
        && !req_valid_reg;
    wire emit_start = done_take && req_reg.frame_id != '0;
    wire [7:0] emit_status = req_reg.broadcast ? STAT_OK : done_status;
    wire emit_busy;

    // Frame byte intake stalls only while a request is in flight or its status frame is being sent
    assign rx_ready = state_reg != ST_WAIT && state_reg != ST_EMIT;
    assign req = req_reg;
    assign req_valid = req_valid_reg;
    assign frame_drop = drop_reg;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (take && rx_data == START_DELIM) begin
                    state_next = ST_LEN_HI;
                end
            end
            ST_LEN_HI: begin
                if (take) begin
                    state_next = ST_LEN_LO;
                end
            end
            ST_LEN_LO: begin
                if (take) begin
                    state_next = len_word == '0 ? ST_CKSUM : ST_BODY;
                end
            end
            ST_BODY: begin
                if (take && pay_last) begin
                    state_next = ST_CKSUM;
                end
            end
            ST_CKSUM: begin
                if (good) begin
                    state_next = ST_WAIT;
                end else if (bad) begin
                    state_next = ST_IDLE;
                end
            end
            ST_WAIT: begin
                if (emit_start) begin
                    state_next = ST_EMIT;
                end else if (done_take) begin
                    state_next = ST_IDLE;
                end
            end
            ST_EMIT: begin
                if (!emit_busy) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ST_IDLE;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    // Length and position tracking
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            len_hi_reg <= '0;
            rem_reg <= '0;
            bidx_reg <= '0;
        end else if (take) begin
            if (state_reg == ST_LEN_HI) begin
                len_hi_reg <= rx_data;
            end
            if (state_reg == ST_LEN_LO) begin
                rem_reg <= len_word;
                bidx_reg <= '0;
            end else if (in_body) begin
                rem_reg <= rem_reg - ONE16;
                bidx_reg <= bidx_reg + ONE16;
            end
        end
    end

    // Running sum over type byte through last payload byte
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sum_reg <= '0;
        end else if (take) begin
            if (state_reg == ST_LEN_LO) begin
                sum_reg <= '0;
            end else if (in_body) begin
                sum_reg <= sum_reg + rx_data;
            end
        end
    end

    // Header field capture
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            type_ok_reg <= 1'b0;
            long_reg <= 1'b0;
            id_reg <= '0;
            dest_reg <= '0;
            opt_reg <= '0;
        end else if (take) begin
            if (state_reg == ST_LEN_LO) begin
                type_ok_reg <= 1'b0;
                dest_reg <= '0;
                opt_reg <= '0;
            end
            if (is_type) begin
                type_ok_reg <= rx_data == TYPE_TX64
                    || rx_data == TYPE_TX16;
                long_reg <= rx_data == TYPE_TX64;
            end
            if (is_id) begin
                id_reg <= rx_data;
            end
            if (is_dest) begin
                dest_reg <= {dest_reg[55:0], rx_data};
            end
            if (is_opt) begin
                opt_reg <= rx_data;
            end
        end
    end

    // Payload longer than the buffer cannot be committed, so it is dropped
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ovf_reg <= 1'b0;
        end else if (take) begin
            if (state_reg == ST_LEN_LO) begin
                ovf_reg <= 1'b0;
            end else if (is_pay && !fifo_in_ready) begin
                ovf_reg <= 1'b1;
            end
        end
    end

    // Request descriptor, published only after the checksum verifies
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            req_reg <= '0;
            req_valid_reg <= 1'b0;
            drop_reg <= 1'b0;
        end else if (clk_en) begin
            drop_reg <= bad;
            if (good) begin
                req_valid_reg <= 1'b1;
                req_reg.long_addr <= long_reg;
                req_reg.dest <= dest_reg;
                req_reg.frame_id <= id_reg;
                req_reg.broadcast <= bcast_hit;
                req_reg.no_ack <= opt_reg[OPT_NO_ACK];
                req_reg.bcast_pan <= opt_reg[OPT_BCAST_PAN];
            end else if (req_valid_reg && req_ready) begin
                req_valid_reg <= 1'b0;
            end
        end
    end

    ltf_fifo #(
        .WIDTH($bits(ltf_byte_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data({rx_data, pay_last}),
        .commit(good),
        .drop(bad),
        .out_valid(pay_valid),
        .out_ready(pay_ready),
        .out_data(pay_data)
    );

    ltf_status_tx u_status (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .start(emit_start),
        .frame_id(req_reg.frame_id),
        .status(emit_status),
        .busy(emit_busy),
        .tx_valid(tx_valid),
        .tx_ready(tx_ready),
        .tx_data(tx_data)
    );

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    AST_START_ONLY_DELIM: assert property (
        state_reg == ST_IDLE && take && rx_data != START_DELIM
        |=> state_reg == ST_IDLE)
        else $error("idle left on a non-delimiter byte");

    AST_LEN_LOAD: assert property (
        take && state_reg == ST_LEN_LO
        |=> rem_reg == $past(len_word) && bidx_reg == '0)
        else $error("length field not loaded");

    AST_TYPE_LONG: assert property (
        take && is_type && rx_data == TYPE_TX64
        |=> long_reg && type_ok_reg)
        else $error("long request type not decoded");

    AST_TYPE_SHORT: assert property (
        take && is_type && rx_data == TYPE_TX16
        |=> !long_reg && type_ok_reg)
        else $error("short request type not decoded");

    AST_ZERO_ID_SILENT: assert property (
        done_take && req_reg.frame_id == '0
        |=> !tx_valid && state_reg == ST_IDLE)
        else $error("status sent for zero identifier");

    AST_ID_ECHO: assert property (
        emit_start |=> u_status.id_reg == $past(req_reg.frame_id))
        else $error("status identifier differs from request");

    AST_STATUS_FRAME: assert property (
        emit_start |=> tx_valid && tx_data == START_DELIM)
        else $error("status frame does not open with delimiter");

    AST_BCAST_OK: assert property (
        emit_start && req_reg.broadcast |=> u_status.st_reg == STAT_OK)
        else $error("broadcast status not success");

    AST_GOOD_PUBLISH: assert property (
        good |=> req_valid_reg && state_reg == ST_WAIT)
        else $error("verified frame not published");

    AST_BAD_SILENT: assert property (
        bad |=> !req_valid_reg && drop_reg && state_reg == ST_IDLE)
        else $error("bad frame not discarded");

    AST_OPTS: assert property (
        good |=> req_reg.no_ack == $past(opt_reg[OPT_NO_ACK])
        && req_reg.bcast_pan == $past(opt_reg[OPT_BCAST_PAN]))
        else $error("options not applied independently");

    COV_GOOD_LONG: cover property (good && long_reg);
    COV_GOOD_SHORT: cover property (good && !long_reg);
    COV_BAD_FRAME: cover property (bad);
    COV_STATUS_SENT: cover property (emit_start ##[1:20] !emit_busy);
endmodule

//--- ltf_pkg.sv
// Purpose: shared constants and types for the legacy transmit framer
// Assumes: one byte per handshake on every stream except req, which carries one descriptor
// Notes: body index = frame offset minus the type byte offset
package ltf_pkg;
    localparam int BYTE_W = 8;
    localparam int FIFO_DEPTH = 32;
    localparam logic [7:0] START_DELIM = 8'h7E;
    localparam logic [7:0] TYPE_TX64 = 8'h00;
    localparam logic [7:0] TYPE_TX16 = 8'h01;
    localparam logic [7:0] TYPE_TXSTAT = 8'h89;
    localparam logic [7:0] CKSUM_BASE = 8'hFF;
    localparam logic [7:0] STAT_OK = 8'h00;
    localparam logic [15:0] STAT_LEN = 16'h0003;
    localparam logic [15:0] OFS_TYPE = 16'h0003;
    localparam logic [15:0] OFS_ID = 16'h0004;
    localparam logic [15:0] OFS_DEST = 16'h0005;
    localparam logic [15:0] OFS_OPT64 = 16'h000D;
    localparam logic [15:0] OFS_OPT16 = 16'h0007;
    localparam logic [15:0] OFS_PAY64 = 16'h000E;
    localparam logic [15:0] OFS_PAY16 = 16'h0008;
    localparam logic [15:0] BI_ID = OFS_ID - OFS_TYPE;
    localparam logic [15:0] BI_DEST = OFS_DEST - OFS_TYPE;
    localparam logic [15:0] BI_OPT64 = OFS_OPT64 - OFS_TYPE;
    localparam logic [15:0] BI_OPT16 = OFS_OPT16 - OFS_TYPE;
    localparam logic [15:0] BI_PAY64 = OFS_PAY64 - OFS_TYPE;
    localparam logic [15:0] BI_PAY16 = OFS_PAY16 - OFS_TYPE;
    localparam logic [15:0] ONE16 = 16'h0001;
    localparam logic [63:0] BCAST64 = 64'h000000000000FFFF;
    localparam logic [15:0] BCAST16 = 16'hFFFF;
    localparam int OPT_NO_ACK = 0;
    localparam int OPT_BCAST_PAN = 2;
    localparam logic [2:0] EMIT_LAST = 3'h6;

    typedef struct packed {
        logic long_addr;
        logic [63:0] dest;
        logic [7:0] frame_id;
        logic broadcast;
        logic no_ack;
        logic bcast_pan;
    } ltf_req_t;

    typedef struct packed {
        logic [7:0] data;
        logic last;
    } ltf_byte_t;
endpackage

//--- ltf_fifo.sv
// Purpose: payload buffer with commit and drop of a pending frame
// Assumes: reader sees only bytes that were committed
// Notes: drop rewinds the write pointer to the last commit
`timescale 1ns/1ps
module ltf_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic commit,
    input wire logic drop,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_reg, cm_reg, rd_reg;
    logic [AW:0] used;
    wire push = clk_en && in_valid && in_ready;
    wire pop = clk_en && out_valid && out_ready;

    assign used = wr_reg - rd_reg;
    assign in_ready = used != (AW+1)'(DEPTH);
    assign out_valid = cm_reg != rd_reg;
    assign out_data = mem[rd_reg[AW-1:0]];

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_reg[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_reg <= '0;
            cm_reg <= '0;
            rd_reg <= '0;
        end else if (clk_en) begin
            if (drop) begin
                wr_reg <= cm_reg;
            end else if (push) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (commit) begin
                cm_reg <= push ? wr_reg + 1'b1 : wr_reg;
            end
            if (pop) begin
                rd_reg <= rd_reg + 1'b1;
            end
        end
    end
endmodule

//--- ltf_status_tx.sv
// Purpose: serialises one seven-byte transmit-status frame
// Assumes: start only while not busy
// Notes: data held in a flop until the host takes it
`timescale 1ns/1ps
module ltf_status_tx
    import ltf_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic start,
    input wire logic [7:0] frame_id,
    input wire logic [7:0] status,
    output logic busy,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [7:0] tx_data
);
    logic [2:0] idx_reg;
    logic [7:0] id_reg, st_reg;
    logic [7:0] sum;
    logic [7:0] nxt;

    assign busy = tx_valid;
    assign sum = TYPE_TXSTAT + id_reg + st_reg;
    always_comb begin
        case (idx_reg)
            3'h0: nxt = STAT_LEN[15:8];
            3'h1: nxt = STAT_LEN[7:0];
            3'h2: nxt = TYPE_TXSTAT;
            3'h3: nxt = id_reg;
            3'h4: nxt = st_reg;
            default: nxt = CKSUM_BASE - sum;
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            idx_reg <= '0;
            id_reg <= '0;
            st_reg <= '0;
            tx_valid <= 1'b0;
            tx_data <= '0;
        end else if (clk_en) begin
            if (start) begin
                idx_reg <= '0;
                id_reg <= frame_id;
                st_reg <= status;
                tx_valid <= 1'b1;
                tx_data <= START_DELIM;
            end else if (tx_valid && tx_ready) begin
                tx_valid <= idx_reg != EMIT_LAST;
                idx_reg <= idx_reg + 1'b1;
                tx_data <= nxt;
            end
        end
    end
endmodule

//--- ltf_host_model.sv
// Purpose: host stand-in that frames transmit requests and takes status
// Assumes: clk_en held high, so one rising edge is one transfer
// Notes: a released data line shows the inverse of its last byte
`timescale 1ns/1ps
module ltf_host_model
    import ltf_pkg::*;
(
    input wire logic core_clk,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [7:0] rx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] tx_data
);
    logic [7:0] txq[$];
    logic slow = 1'b0;
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        tx_ready = 1'b0;
    end
    // Slow mode drops ready on every other cycle to stretch the frame
    always @(posedge core_clk) begin
        if (tx_valid && tx_ready)
            txq.push_back(tx_data);
        tx_ready <= slow ? !tx_ready : 1'b1;
    end
    task automatic send(input logic lng, input logic [63:0] dst,
        input logic [7:0] id, input logic [7:0] opt, input int np,
        input logic bad);
        logic [7:0] f[$];
        logic [7:0] s;
        logic r;
        f = {lng ? TYPE_TX64 : TYPE_TX16, id};
        for (int k = lng ? 7 : 1; k >= 0; k--)
            f.push_back(dst[8*k +: 8]);
        f.push_back(opt & 8'h05);
        for (int k = 0; k < np; k++)
            f.push_back(8'(k * 7 + 1));
        s = 8'h00;
        foreach (f[i])
            s += f[i];
        f.push_back((CKSUM_BASE - s) ^ {7'h00, bad});
        f.push_front(8'(f.size() - 1));
        f.push_front(8'h00);
        f.push_front(START_DELIM);
        // A stray byte ahead of the delimiter must be skipped
        f.push_front(8'h55);
        foreach (f[i]) begin
            rx_valid <= 1'b1;
            rx_data <= f[i];
            do begin
                @(negedge core_clk);
                r = rx_ready;
                @(posedge core_clk);
            end while (!r);
        end
        rx_valid <= 1'b0;
        rx_data <= ~f[f.size() - 1];
    endtask
endmodule

//--- ltf_framer_tb.sv
// Purpose: self-checking bench for the legacy transmit framer
// Assumes: radio side is played here, host side by ltf_host_model
// Notes: radio takes each payload byte on alternate cycles as a stall
`timescale 1ns/1ps
module ltf_framer_tb;
    import ltf_pkg::*;
    logic core_clk, reset_n, clk_en, rx_valid, rx_ready, req_valid;
    logic req_ready, pay_valid, pay_ready, done_valid, tx_valid;
    logic tx_ready, frame_drop;
    logic [7:0] rx_data, done_status, tx_data;
    ltf_req_t req;
    ltf_byte_t pay_data;
    int fails = 0;
    int n_compared = 0;
    int cyc = 0;

    ltf_framer dut_u (
        .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
        .req(req), .req_valid(req_valid), .req_ready(req_ready),
        .pay_valid(pay_valid), .pay_ready(pay_ready),
        .pay_data(pay_data), .done_valid(done_valid),
        .done_status(done_status), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_data(tx_data), .frame_drop(frame_drop)
    );
    ltf_host_model host_u (
        .core_clk(core_clk), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_data(tx_data)
    );

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Generous ceiling: the whole sequence needs under two thousand cycles
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            fails++;
            close_out();
        end
    end

    task automatic chk(input string nm, input logic [63:0] ex,
        input logic [63:0] got);
        n_compared++;
        if (got !== ex) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic wait_for(input int w, output logic got);
        got = 1'b0;
        for (int n = 0; n < 40 && !got; n++) begin
            @(negedge core_clk);
            got = ((w == 0) ? req_valid : (w == 1) ? pay_valid :
                frame_drop) === 1'b1;
        end
    endtask

    task automatic xfer(input string nm, input logic lng,
        input logic [63:0] dst, input logic [7:0] id, input logic [7:0] opt,
        input logic [7:0] st, input int np, input logic bad);
        logic got;
        logic bc;
        logic [7:0] es;
        logic [7:0] ex[7];
        bc = lng ? dst === BCAST64 : dst[15:0] === BCAST16;
        es = bc ? STAT_OK : st;
        ex = '{START_DELIM, 8'h00, 8'h03, TYPE_TXSTAT, id, es,
            CKSUM_BASE - (TYPE_TXSTAT + id + es)};
        host_u.txq.delete();
        host_u.send(lng, dst, id, opt, np, bad);
        if (bad || np > FIFO_DEPTH) begin
            wait_for(2, got);
            chk("frame_drop", 1, got);
            chk("req_valid", 0, req_valid);
        end else begin
            wait_for(0, got);
            chk("req_valid", 1, got);
            chk("rx_ready", 0, rx_ready);
            chk("long_addr", lng, req.long_addr);
            chk("dest", lng ? dst : {48'h0, dst[15:0]}, req.dest);
            chk("frame_id", id, req.frame_id);
            chk("broadcast", bc, req.broadcast);
            chk("no_ack", opt[0], req.no_ack);
            chk("bcast_pan", opt[2], req.bcast_pan);
            // Enable low must hold the descriptor although ready is high
            @(posedge core_clk);
            clk_en <= 1'b0;
            req_ready <= 1'b1;
            repeat (2) @(posedge core_clk);
            @(negedge core_clk);
            chk("frozen_req_valid", 1, req_valid);
            @(posedge core_clk);
            clk_en <= 1'b1;
            @(posedge core_clk);
            req_ready <= 1'b0;
            for (int k = 0; k < np; k++) begin
                wait_for(1, got);
                chk("pay", {8'(k * 7 + 1), k == np - 1}, pay_data);
                @(posedge core_clk);
                pay_ready <= 1'b1;
                @(posedge core_clk);
                pay_ready <= 1'b0;
            end
            @(negedge core_clk);
            chk("pay_valid", 0, pay_valid);
            @(posedge core_clk);
            done_valid <= 1'b1;
            done_status <= st;
            @(posedge core_clk);
            done_valid <= 1'b0;
            done_status <= ~st;
            for (int n = 0; n < 40 && host_u.txq.size() < 7; n++)
                @(posedge core_clk);
            chk("status_len", id == 8'h00 ? 0 : 7, host_u.txq.size());
            foreach (ex[i])
                if (i < host_u.txq.size())
                    chk("status", ex[i], host_u.txq[i]);
            repeat (2) @(negedge core_clk);
            chk("rx_ready", 1, rx_ready);
        end
        $display("test %s done", nm);
    endtask

    task automatic sc_long;
        xfer("long", 1'b1, 64'h0013A20012345678, 8'h52, 8'h01, 8'h01, 6,
            1'b0);
    endtask

    task automatic sc_long_bcast;
        host_u.slow = 1'b1;
        xfer("long_bcast", 1'b1, BCAST64, 8'h33, 8'h05, 8'h02, 9,
            1'b0);
        host_u.slow = 1'b0;
    endtask

    task automatic sc_short;
        xfer("short", 1'b0, 64'h1234, 8'h87, 8'h04, 8'h00, 0, 1'b0);
    endtask

    task automatic sc_short_bcast;
        xfer("short_bcast", 1'b0, 64'hFFFF, 8'h00, 8'h00, 8'h04, 9,
            1'b0);
    endtask

    task automatic sc_bad_sum;
        xfer("bad_sum", 1'b0, 64'h1234, 8'h11, 8'h01, 8'h00, 3, 1'b1);
    endtask

    task automatic sc_fifo_edge;
        xfer("overfull", 1'b1, 64'h42, 8'h21, 8'h00, 8'h00, 33, 1'b0);
        xfer("full", 1'b1, 64'h42, 8'h22, 8'h00, 8'h01, 32,
            1'b0);
    endtask

    initial begin
        reset_n = 1'b0;
        clk_en = 1'b1;
        req_ready = 1'b0;
        pay_ready = 1'b0;
        done_valid = 1'b0;
        done_status = 8'h00;
        repeat (5) @(posedge core_clk);
        chk("reset_req_valid", 0, req_valid);
        reset_n <= 1'b1;
        sc_long();
        sc_long_bcast();
        sc_short();
        sc_short_bcast();
        sc_bad_sum();
        sc_fifo_edge();
        close_out();
    end
endmodule
